// ===== logic/wdtr_map.vh
// Purpose: Constants for the software watchdog with reset sequencing.
// Assumes: One 10 MHz clock; one E cycle is one clock cycle.
// Notes: Register addresses are byte addresses on the plain register port.
`ifndef WDTR_MAP_VH
`define WDTR_MAP_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define WDTR_ADDR_SERVICE 16'h103a
`define WDTR_ADDR_CONFIG 16'h103b
`define WDTR_ADDR_STATUS 16'h103c
`define WDTR_SVC_ARM 8'h55
`define WDTR_SVC_FIRE 8'haa
// Config fields: bit 1 timeout_select_hi, bit 0 timeout_select_lo, bit 2 disable cell.
`define WDTR_CFG_SEL_LO 0
`define WDTR_CFG_SEL_HI 1
`define WDTR_CFG_DISABLE 2
// ----------------------------------------
// Timing and vectors
// ----------------------------------------
`define WDTR_PRESCALE_BITS 15
`define WDTR_SEL_WINDOW 8'h40
`define WDTR_PIN_DRIVE 3'h4
`define WDTR_PIN_WAIT 3'h2
`define WDTR_PIN_SYNC 3'h4
`define WDTR_VEC_EXTERNAL 2'h0
`define WDTR_VEC_WATCHDOG 2'h1
`define WDTR_VEC_CLOCK_MON 2'h2
`endif

// ===== logic/wdtr_sync.v
// Purpose: Three-stage synchroniser for the reset pin input.
// Assumes: Input is asynchronous to clock.
// Notes: A change counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module wdtr_sync (
  input wire clock,
  input wire rstn,
  input wire din,
  output reg dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // Shift the pin through three flops and accept only agreeing samples.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // wdtr_sync
`default_nettype wire

// ===== logic/wdtr_top.v
// Purpose: Software watchdog that forces a system reset when not serviced.
// Assumes: Clock is the E clock; the prescaler is 2^15 cycles.
// Notes: The disable cell is a persistent strap sampled after reset.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "wdtr_map.vh"
module wdtr_top #(
  parameter PRE_BITS = `WDTR_PRESCALE_BITS
) (
  input wire clock,
  input wire rstn,
  input wire [15:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  input wire watchdog_disable_cell,
  input wire special_mode,
  input wire reset_pin_in,
  output reg reset_pin_out,
  output reg reset_pin_oe_n,
  output reg reset_req,
  output reg [1:0] reset_vector,
  output reg vector_valid
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam ST_RUN = 2'h0;
  localparam ST_DRIVE = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_SETTLE = 2'h3;
  reg disable_q;
  reg strap_taken_q;
  reg sel_hi_q;
  reg sel_lo_q;
  reg sel_locked_q;
  reg [7:0] age_q;
  reg armed_q;
  reg [PRE_BITS-1:0] pre_q;
  reg [6:0] slow_q;
  reg [1:0] st_q;
  reg [2:0] cnt_q;
  reg fired_q;
  wire pin_sync;
  wire [PRE_BITS-1:0] pre_max;
  wire pre_tick;
  wire enabled;
  wire wr_svc;
  wire wr_cfg;
  wire svc_clear;
  wire [6:0] slow_lim;
  wire timeout;

  // Decode an address match for a register strobe.
  function hit;
    input [15:0] a;
    input [15:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  // Synchronise the bidirectional reset pin input.
  wdtr_sync u_sync (
    .clock(clock),
    .rstn(rstn),
    .din(reset_pin_in),
    .dout(pin_sync)
  );

  // Strobes, enable and timeout terms.
  assign wr_svc = wr_stb & hit(addr, `WDTR_ADDR_SERVICE);
  assign wr_cfg = wr_stb & hit(addr, `WDTR_ADDR_CONFIG);
  assign enabled = ~disable_q & ~special_mode;
  assign svc_clear = wr_svc & armed_q & (wdata == `WDTR_SVC_FIRE);
  assign pre_max = {PRE_BITS{1'b1}};
  assign pre_tick = (pre_q == pre_max);
  // Slow counter limit: 1, 4, 16 or 64 prescaler periods.
  assign slow_lim = {sel_hi_q & sel_lo_q, 1'b0, sel_hi_q & ~sel_lo_q, 1'b0,
    ~sel_hi_q & sel_lo_q, 1'b0, ~sel_hi_q & ~sel_lo_q} - 7'h01;
  assign timeout = enabled & pre_tick & (slow_q == slow_lim) & (st_q == ST_RUN);

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  // Capture the persistent disable cell once after reset release.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      disable_q <= 1'b1;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      disable_q <= watchdog_disable_cell;
      strap_taken_q <= 1'b1;
    end
  end

  // Timeout select: cleared by reset, one write within 64 cycles; any write at any time in special mode.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_hi_q <= 1'b0;
      sel_lo_q <= 1'b0;
      sel_locked_q <= 1'b0;
      age_q <= 8'h00;
    end else begin
      if (age_q != `WDTR_SEL_WINDOW) begin
        age_q <= age_q + 8'h01;
      end
      if (wr_cfg && (special_mode || (!sel_locked_q && age_q != `WDTR_SEL_WINDOW))) begin
        sel_hi_q <= wdata[`WDTR_CFG_SEL_HI];
        sel_lo_q <= wdata[`WDTR_CFG_SEL_LO];
        sel_locked_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Service sequence and counter
  // ----------------------------------------
  // Arm on 0x55, fire on armed 0xaa, other service writes disarm; reads and writes elsewhere do nothing.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      armed_q <= 1'b0;
    end else if (wr_svc) begin
      armed_q <= (wdata == `WDTR_SVC_ARM);
    end
  end

  // Prescaler and slow counter; a completed service pair clears the slow counter only.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_q <= {PRE_BITS{1'b0}};
      slow_q <= 7'h00;
    end else if (svc_clear || !enabled || st_q != ST_RUN) begin
      slow_q <= 7'h00;
      if (!enabled || st_q != ST_RUN) begin
        pre_q <= {PRE_BITS{1'b0}};
      end else begin
        pre_q <= pre_q + {{(PRE_BITS-1){1'b0}}, 1'b1};
      end
    end else begin
      pre_q <= pre_q + {{(PRE_BITS-1){1'b0}}, 1'b1};
      if (pre_tick) begin
        slow_q <= (slow_q == slow_lim) ? 7'h00 : slow_q + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // Reset pin sequencing
  // ----------------------------------------
  // Drive the pin low four cycles, release, sample two cycles later.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_RUN;
      cnt_q <= 3'h0;
      fired_q <= 1'b0;
      reset_pin_out <= 1'b1;
      reset_pin_oe_n <= 1'b1;
      reset_req <= 1'b0;
      reset_vector <= `WDTR_VEC_EXTERNAL;
      vector_valid <= 1'b0;
    end else begin
      vector_valid <= 1'b0;
      case (st_q)
        ST_RUN: begin
          if (timeout) begin
            st_q <= ST_DRIVE;
            cnt_q <= 3'h0;
            fired_q <= 1'b1;
            reset_req <= 1'b1;
            reset_pin_out <= 1'b0;
            reset_pin_oe_n <= 1'b0;
          end
        end
        ST_DRIVE: begin
          if (cnt_q == `WDTR_PIN_DRIVE - 3'h1) begin
            reset_pin_oe_n <= 1'b1;
            reset_pin_out <= 1'b1;
            st_q <= ST_WAIT;
            cnt_q <= 3'h0;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        ST_WAIT: begin
          if (cnt_q == `WDTR_PIN_WAIT - 3'h1) begin
            // The pin level enters the synchroniser now; wait for it to emerge.
            st_q <= ST_SETTLE;
            cnt_q <= 3'h0;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        ST_SETTLE: begin
          if (cnt_q == `WDTR_PIN_SYNC - 3'h1) begin
            // The synchronised sample is the pin level two cycles after release.
            // High pin means internal source: watchdog vector.
            reset_vector <= pin_sync ? `WDTR_VEC_WATCHDOG : `WDTR_VEC_EXTERNAL;
            vector_valid <= 1'b1;
            reset_req <= 1'b0;
            st_q <= ST_RUN;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        default: begin
          st_q <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Read data stand one cycle after the read strobe; service reads give zero.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd_stb && hit(addr, `WDTR_ADDR_CONFIG)) begin
      rdata <= {5'h00, disable_q, sel_hi_q, sel_lo_q};
    end else if (rd_stb && hit(addr, `WDTR_ADDR_STATUS)) begin
      rdata <= {3'h0, fired_q, sel_locked_q, armed_q, enabled, reset_req};
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // wdtr_top
`default_nettype wire

// ===== dv/wdtr_chk_sva.sv
// Purpose: Port assertions for the watchdog reset block.
// Assumes: One clock domain with rstn active low.
// Notes: Bound to wdtr_top from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module wdtr_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] addr,
  input wire logic rd_stb,
  input wire logic special_mode,
  input wire logic [7:0] rdata,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe_n,
  input wire logic reset_req,
  input wire logic [1:0] reset_vector,
  input wire logic vector_valid
);
  // ----------------------------------------
  // Reset sequencing and read checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Pin drive, release, then the vector report.
  sequence s_drive;
    !reset_pin_oe_n [*4] ##1 reset_pin_oe_n [*6] ##1 vector_valid;
  endsequence
  // Request held through drive, wait and synchroniser settling.
  sequence s_req_hold;
    reset_req [*8] ##1 reset_req [*2] ##1 !reset_req;
  endsequence
  chk_pin_drive: assert property ($rose(reset_req) |-> s_drive)
    else $error("pin drive sequence wrong");
  chk_drive_low: assert property (!reset_pin_oe_n |-> reset_req && !reset_pin_out)
    else $error("pin driven outside a reset or not low");
  chk_pin_release: assert property (reset_pin_oe_n |-> reset_pin_out)
    else $error("released pin output not high");
  chk_req_length: assert property ($rose(reset_req) |-> s_req_hold)
    else $error("reset request length wrong");
  chk_vec_end: assert property (vector_valid |-> $fell(reset_req))
    else $error("vector reported apart from request end");
  chk_vec_pulse: assert property (vector_valid |=> !vector_valid)
    else $error("vector valid longer than one cycle");
  chk_vec_code: assert property (vector_valid |-> reset_vector != 2'h2)
    else $error("vector reported as clock monitor");
  chk_special_quiet: assert property (special_mode && !reset_req |=> !reset_req)
    else $error("reset raised in special mode");
  chk_read_quiet: assert property (!$past(rd_stb) || $past(addr) == 16'h103a |-> rdata == 8'h00)
    else $error("read data not zero");
endmodule // wdtr_chk
`default_nettype wire

// ===== dv/tb.sv
// Purpose: Self-checking bench for the watchdog reset block.
// Assumes: PRE_BITS is 4, so one prescaler tick is 16 clocks.
// Notes: The reset pin is pulled up unless the bench or the block drives it low.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------
  // Stimulus, scoreboard and scenarios
  // ----------------------------------------
  logic clock = 0, rstn = 0, wr_stb = 0, rd_stb = 0, strap = 0, special_mode = 0, ext_n = 1, rv = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [1:0] reset_vector;
  logic reset_pin_out, reset_pin_oe_n, reset_req, vector_valid;
  int failures = 0, check_count = 0, seed = 32'hfc33, n;
  logic [7:0] qr[$];
  logic [1:0] qv[$];
  wire pin = ext_n & (reset_pin_oe_n | reset_pin_out);
  always #50 clock = ~clock;
  wdtr_top #(.PRE_BITS(4)) i_wdtr_top (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .watchdog_disable_cell(strap),
    .special_mode(special_mode), .reset_pin_in(pin), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n), .reset_req(reset_req), .reset_vector(reset_vector),
    .vector_valid(vector_valid));
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    qr.push_back(e);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
  endtask
  task automatic do_reset(input logic s);
    @(posedge clock);
    rstn <= 1'b0;
    strap <= s;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
  endtask
  // Bounded wait for a reset request; a hang ends the run.
  task automatic wait_req(input int lim, output int c);
    for (c = 0; c < lim && reset_req !== 1'b1; c++) @(posedge clock);
    if (c >= lim) begin
      failures++;
      $display("[ERR] reset_req expected 1 seen 0");
      tally_and_finish();
    end
    repeat (16) @(posedge clock);
  endtask
  // Each read answer and vector report is matched against the oldest note.
  always @(posedge clock) begin
    rv <= rd_stb;
    if (rv && qr.size() > 0) cmp("rdata", qr.pop_front(), rdata);
    if (vector_valid === 1'b1) cmp("vector", qv.size() ? {6'h0, qv.pop_front()} : 8'hff, {6'h0, reset_vector});
  end
  // Scenarios run in order; each prints one line when it ends.
  initial begin
    do_reset(1'b0);
    wr(16'h103a, 8'h55);
    wr(16'h103a, 8'haa);
    rd(16'h103c, 8'h02);
    rd(16'h103b, 8'h00);
    wr(16'h103b, 8'h01);
    wr(16'h103b, 8'h02);
    rd(16'h103b, 8'h01);
    rd(16'h103a, 8'h00);
    rd(16'h1000, 8'h00);
    $display("test config done");
    for (n = 0; n < 20; n++) begin
      wr(16'h103a, 8'h55);
      repeat ($unsigned($random(seed)) % 8) @(posedge clock);
      wr(16'h1000, $random(seed));
      wr(16'h103a, 8'haa);
    end
    cmp("no_reset", 8'h00, {7'h0, reset_req});
    qv.push_back(2'h1);
    wait_req(200, n);
    cmp("period", 8'h01, {7'h0, n >= 48 && n <= 82});
    rd(16'h103c, 8'h1a);
    $display("test service done");
    ext_n <= 1'b0;
    qv.push_back(2'h0);
    for (n = 0; n < 40 && reset_req !== 1'b1; n++) wr(16'h103a, 8'haa);
    wait_req(20, n);
    ext_n <= 1'b1;
    $display("test external done");
    do_reset(1'b1);
    repeat (150) @(posedge clock);
    cmp("disabled", 8'h00, {7'h0, reset_req});
    wr(16'h103b, 8'h03);
    rd(16'h103b, 8'h04);
    rd(16'h103c, 8'h00);
    $display("test disabled done");
    do_reset(1'b0);
    special_mode <= 1'b1;
    wr(16'h103b, 8'h03);
    rd(16'h103b, 8'h03);
    wr(16'h103b, 8'h00);
    repeat (150) @(posedge clock);
    cmp("special", 8'h00, {7'h0, reset_req});
    special_mode <= 1'b0;
    qv.push_back(2'h1);
    wait_req(60, n);
    cmp("short", 8'h01, {7'h0, n <= 34});
    $display("test special done");
    cmp("pending", 8'h00, {7'h0, qv.size() + qr.size() != 0});
    tally_and_finish();
  end
endmodule // tb
bind wdtr_top wdtr_chk i_wdtr_chk (.clock(clock), .rstn(rstn), .addr(addr), .rd_stb(rd_stb),
  .special_mode(special_mode), .rdata(rdata), .reset_pin_out(reset_pin_out),
  .reset_pin_oe_n(reset_pin_oe_n), .reset_req(reset_req), .reset_vector(reset_vector),
  .vector_valid(vector_valid));
`default_nettype wire
